// ---- logic/fls_map.svh ----
// offsets, widths and timing counts for the forward link spreader
`ifndef FLS_MAP_SVH
`define FLS_MAP_SVH
`define FLS_SAMPLE_WIDTH 16
`define FLS_CHIP_WIDTH 17
`define FLS_SF_WIDTH 3
`define FLS_SF_MIN 3'h1
`define FLS_SF_MAX 3'h4
`define FLS_SF_RESET 3'h1
`define FLS_CODE_RESET 4'hf
`define FLS_SCRAM_PERIOD 17'h10374
`define FLS_SCRAM_PERIOD_LAST 17'h10373
`define FLS_SEED_X 18'h00001
`define FLS_SEED_Y 18'h3ffff
`define FLS_GOLD_RESET 18'h00000
`define FLS_FRAME_COUNT_WIDTH 24
`endif

// ---- logic/fls_pkg.sv ----
// types for the forward link spreader
package fls_pkg;
   typedef enum logic [1:0] {
      fls_idle,
      fls_run
   } fls_state_type;
   typedef logic signed [15:0] fls_sample_type;
   typedef logic signed [16:0] fls_chip_type;
endpackage : fls_pkg

// ---- logic/fls_scrambler_gen.sv ----
// complex scrambling code generator, two m-sequences over gold code index
`timescale 1ns/10ps
`include "fls_map.svh"
module fls_scrambler_gen (
   input wire logic clk,
   input wire logic rst,
   input wire logic restart,
   input wire logic advance,
   input wire logic [17:0] gold_index,
   output logic [1:0] code_sym
);
   logic [17:0] x;
   logic [17:0] y;
   logic [16:0] pos;
   logic [17:0] next_x;
   logic [17:0] next_y;
   logic [16:0] next_pos;
   logic zn;
   logic zn2;
   logic x_fb;
   logic y_fb;
   logic [17:0] x_seed;
   always_comb begin
      next_x = x;
      next_y = y;
      next_pos = pos;
      x_fb = x[7] ^ x[0];
      y_fb = y[10] ^ y[7] ^ y[5] ^ y[0];
      x_seed = `FLS_SEED_X;
      // seed x advanced gold_index times approximated by xor offset
      x_seed = x_seed ^ gold_index;
      if (x_seed == 18'h00000) begin
         x_seed = `FLS_SEED_X;
      end
      if (restart) begin
         next_x = x_seed;
         next_y = `FLS_SEED_Y;
         next_pos = 17'h00000;
      end else if (advance) begin
         if (pos == `FLS_SCRAM_PERIOD_LAST) begin
            // wrap at period of 66420
            next_x = x_seed;
            next_y = `FLS_SEED_Y;
            next_pos = 17'h00000;
         end else begin
            next_x = {x_fb, x[17:1]};
            next_y = {y_fb, y[17:1]};
            next_pos = pos + 17'h00001;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         x <= `FLS_SEED_X;
         y <= `FLS_SEED_Y;
         pos <= 17'h00000;
      end else begin
         x <= next_x;
         y <= next_y;
         pos <= next_pos;
      end
   end
   always_comb begin
      zn = x[0] ^ y[0];
      zn2 = (x[4] ^ x[6] ^ x[15]) ^ (y[5] ^ y[6] ^ y[8] ^ y[9] ^ y[10] ^ y[11] ^ y[12] ^ y[13] ^ y[14] ^ y[15]);
      code_sym = {zn2, 1'b0} + {1'b0, zn};
   end
endmodule : fls_scrambler_gen

// ---- logic/fls_spreader.sv ----
// forward link spreader: per-symbol spreading then frame-aligned scrambling, both bypassed at factor 1
`timescale 1ns/10ps
`include "fls_map.svh"
module fls_spreader (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] chips_per_symbol,
   input wire logic [3:0] spread_code,
   input wire logic [17:0] gold_index,
   input wire logic [23:0] frame_symbol_count,
   input wire logic sym_valid,
   input wire logic sym_first,
   input wire fls_pkg::fls_sample_type sym_i,
   input wire fls_pkg::fls_sample_type sym_q,
   output logic sym_ready,
   output logic chip_valid,
   output logic chip_first,
   output logic chip_last,
   output fls_pkg::fls_chip_type chip_i,
   output fls_pkg::fls_chip_type chip_q,
   output logic frame_active
);
   fls_pkg::fls_state_type state;
   fls_pkg::fls_state_type next_state;
   logic [2:0] sf;
   logic [2:0] next_sf;
   logic [3:0] code;
   logic [3:0] next_code;
   logic [17:0] gold;
   logic [17:0] next_gold;
   logic [23:0] frame_len;
   logic [23:0] next_frame_len;
   logic [23:0] sym_count;
   logic [23:0] next_sym_count;
   logic [2:0] chip_idx;
   logic [2:0] next_chip_idx;
   fls_pkg::fls_sample_type hold_i;
   fls_pkg::fls_sample_type next_hold_i;
   fls_pkg::fls_sample_type hold_q;
   fls_pkg::fls_sample_type next_hold_q;
   logic hold_valid;
   logic next_hold_valid;
   logic hold_first;
   logic next_hold_first;
   logic hold_last;
   logic next_hold_last;
   logic scr_restart;
   logic scr_advance;
   logic [1:0] scr_sym;
   logic take;
   logic sym_done;
   logic code_chip;
   fls_pkg::fls_chip_type sp_i;
   fls_pkg::fls_chip_type sp_q;
   fls_pkg::fls_chip_type next_chip_i;
   fls_pkg::fls_chip_type next_chip_q;
   logic next_chip_valid;
   logic next_chip_first;
   logic next_chip_last;
   logic [2:0] sf_in;
   logic [26:0] frame_chip;
   logic [26:0] next_frame_chip;
   logic [26:0] frame_chips;
   logic next_frame_active;

   fls_scrambler_gen u_scrambler (
      .clk(clk),
      .rst(rst),
      .restart(scr_restart),
      .advance(scr_advance),
      .gold_index(gold),
      .code_sym(scr_sym)
   );

   // symbol intake: accept next symbol when the held one finishes its chips
   always_comb begin
      sym_done = hold_valid && (chip_idx == sf - 3'h1);
      sym_ready = !hold_valid || sym_done;
      // non-first symbols only inside a frame
      take = sym_valid && sym_ready && (state == fls_pkg::fls_run || sym_first);
   end

   // clamp requested factor into supported range
   always_comb begin
      sf_in = chips_per_symbol;
      case (chips_per_symbol)
         3'h0: begin
            sf_in = `FLS_SF_MIN;
         end
         3'h1, 3'h2, 3'h3, 3'h4: begin
            sf_in = chips_per_symbol;
         end
         default: begin
            sf_in = `FLS_SF_MAX;
         end
      endcase
   end

   // frame control and held symbol
   always_comb begin
      next_state = state;
      next_sf = sf;
      next_code = code;
      next_gold = gold;
      next_frame_len = frame_len;
      next_sym_count = sym_count;
      next_chip_idx = chip_idx;
      next_hold_i = hold_i;
      next_hold_q = hold_q;
      next_hold_valid = hold_valid;
      next_hold_first = hold_first;
      next_hold_last = hold_last;
      scr_restart = 1'b0;
      if (hold_valid) begin
         if (sym_done) begin
            next_chip_idx = 3'h0;
            next_hold_valid = 1'b0;
         end else begin
            next_chip_idx = chip_idx + 3'h1;
         end
      end
      if (hold_valid && sym_done && hold_last) begin
         next_state = fls_pkg::fls_idle;
      end
      if (take) begin
         next_hold_i = sym_i;
         next_hold_q = sym_q;
         next_hold_valid = 1'b1;
         next_chip_idx = 3'h0;
         if (sym_first) begin
            // latch configuration only here
            next_sf = sf_in;
            next_code = spread_code;
            next_gold = gold_index;
            next_frame_len = frame_symbol_count;
            next_sym_count = 24'h000001;
            next_hold_first = 1'b1;
            next_hold_last = (frame_symbol_count <= 24'h000001);
            next_state = (frame_symbol_count <= 24'h000001) ? fls_pkg::fls_idle : fls_pkg::fls_run;
            scr_restart = 1'b1;
         end else begin
            next_sym_count = sym_count + 24'h000001;
            next_hold_first = 1'b0;
            next_hold_last = (sym_count + 24'h000001 >= frame_len);
         end
      end
      case (state)
         fls_pkg::fls_idle: begin
            // frame opens only on a first symbol
         end
         fls_pkg::fls_run: begin
            // intake runs until the last symbol
         end
         default: begin
            next_state = fls_pkg::fls_idle;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= fls_pkg::fls_idle;
         sf <= `FLS_SF_RESET;
         code <= `FLS_CODE_RESET;
         gold <= `FLS_GOLD_RESET;
         frame_len <= 24'h000000;
         sym_count <= 24'h000000;
         chip_idx <= 3'h0;
         hold_i <= 16'h0000;
         hold_q <= 16'h0000;
         hold_valid <= 1'b0;
         hold_first <= 1'b0;
         hold_last <= 1'b0;
      end else begin
         state <= next_state;
         sf <= next_sf;
         code <= next_code;
         gold <= next_gold;
         frame_len <= next_frame_len;
         sym_count <= next_sym_count;
         chip_idx <= next_chip_idx;
         hold_i <= next_hold_i;
         hold_q <= next_hold_q;
         hold_valid <= next_hold_valid;
         hold_first <= next_hold_first;
         hold_last <= next_hold_last;
      end
   end

   // chip position inside the frame, length is symbols times factor
   always_comb begin
      frame_chips = 27'(frame_len) * 27'(sf);
      next_frame_chip = frame_chip;
      if (scr_restart) begin
         next_frame_chip = 27'h0000000;
      end else if (hold_valid) begin
         next_frame_chip = frame_chip + 27'h0000001;
      end
   end

   // chip position register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frame_chip <= 27'h0000000;
      end else begin
         frame_chip <= next_frame_chip;
      end
   end

   // spreading: chip = symbol component times +/-1 code chip
   always_comb begin
      code_chip = code[chip_idx[1:0]];
      if (code_chip) begin
         sp_i = {hold_i[15], hold_i};
         sp_q = {hold_q[15], hold_q};
      end else begin
         sp_i = -{hold_i[15], hold_i};
         sp_q = -{hold_q[15], hold_q};
      end
   end

   // scrambling follows spreading directly, one chip per cycle
   always_comb begin
      // scrambler advances only within the spread frame
      scr_advance = hold_valid && (frame_chip < frame_chips);
      next_chip_valid = hold_valid;
      next_chip_first = hold_valid && hold_first && (chip_idx == 3'h0);
      next_chip_last = hold_valid && hold_last && sym_done;
      next_chip_i = sp_i;
      next_chip_q = sp_q;
      if (sf == 3'h1) begin
         next_chip_i = {hold_i[15], hold_i};
         next_chip_q = {hold_q[15], hold_q};
      end else begin
         case (scr_sym)
            2'h0: begin
               next_chip_i = sp_i;
               next_chip_q = sp_q;
            end
            2'h1: begin
               next_chip_i = -sp_q;
               next_chip_q = sp_i;
            end
            2'h2: begin
               next_chip_i = -sp_i;
               next_chip_q = -sp_q;
            end
            default: begin
               next_chip_i = sp_q;
               next_chip_q = -sp_i;
            end
         endcase
      end
   end

   // frame activity seen one cycle ahead
   always_comb begin
      next_frame_active = (next_state == fls_pkg::fls_run) || next_hold_valid;
   end

   // registered chip flags toward shaping filter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chip_valid <= 1'b0;
         chip_first <= 1'b0;
         chip_last <= 1'b0;
         frame_active <= 1'b0;
      end else begin
         chip_valid <= next_chip_valid;
         chip_first <= next_chip_first;
         chip_last <= next_chip_last;
         frame_active <= next_frame_active;
      end
   end

   // registered chip values toward shaping filter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chip_i <= 17'h00000;
         chip_q <= 17'h00000;
      end else begin
         chip_i <= next_chip_i;
         chip_q <= next_chip_q;
      end
   end
endmodule : fls_spreader

// ---- tb/fls_framer_model.sv ----
// upstream framer model offering one frame of symbols
`timescale 1ns/10ps
module fls_framer_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic slow,
   input wire logic [23:0] n,
   input wire logic [15:0] val,
   input wire logic sym_ready,
   output logic sym_valid,
   output logic sym_first,
   output fls_pkg::fls_sample_type sym_i,
   output fls_pkg::fls_sample_type sym_q
);
   logic [23:0] k;
   logic busy;
   logic more;
   assign more = (k + 24'h1 != n);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {busy, sym_valid, sym_first, k, sym_i, sym_q} <= '0;
      end else if (go && !busy) begin
         busy <= 1'b1;
         sym_valid <= 1'b1;
         sym_first <= 1'b1;
         k <= '0;
         sym_i <= val;
         sym_q <= -val;
      end else if (busy && !sym_valid) begin
         sym_valid <= 1'b1;
         sym_i <= 16'(val + k);
         sym_q <= 16'(-(val + k));
      end else if (busy && sym_ready) begin
         sym_first <= 1'b0;
         sym_valid <= !slow && more;
         busy <= more;
         k <= k + 24'h1;
         sym_i <= (slow || !more) ? ~sym_i : 16'(val + k + 1);
         sym_q <= (slow || !more) ? ~sym_q : 16'(-(val + k + 1));
      end
   end
endmodule : fls_framer_model

// ---- tb/fls_spreader_sva.sv ----
// port assertions for the spreader
`timescale 1ns/10ps
module fls_spreader_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] chips_per_symbol,
   input wire logic sym_valid,
   input wire logic sym_first,
   input wire fls_pkg::fls_sample_type sym_i,
   input wire fls_pkg::fls_sample_type sym_q,
   input wire logic sym_ready,
   input wire logic chip_valid,
   input wire logic chip_first,
   input wire logic chip_last,
   input wire fls_pkg::fls_chip_type chip_i,
   input wire fls_pkg::fls_chip_type chip_q,
   input wire logic frame_active
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   logic take;
   logic start;
   assign take = sym_valid && sym_ready && (sym_first || frame_active);
   assign start = take && sym_first && !frame_active;
   property p_first_lat;
      start |-> ##2 chip_valid && chip_first;
   endproperty
   a_first_lat: assert property (p_first_lat) else $error("first chip late");
   property p_take_lat;
      take |-> ##2 chip_valid;
   endproperty
   a_take_lat: assert property (p_take_lat) else $error("chip missing");
   property p_sf1;
      start && chips_per_symbol == 3'h1 |-> ##2 chip_i == $past(sym_i, 2) && chip_q == $past(sym_q, 2);
   endproperty
   a_sf1: assert property (p_sf1) else $error("unspread chip differs");
   property p_zero;
      take && sym_i == 16'h0000 && sym_q == 16'h0000 |-> ##2 chip_i == 17'h00000 && chip_q == 17'h00000;
   endproperty
   a_zero: assert property (p_zero) else $error("zero symbol gave nonzero chip");
   property p_rose;
      $rose(frame_active) |-> $past(sym_valid && sym_first);
   endproperty
   a_rose: assert property (p_rose) else $error("frame began without first");
   property p_last;
      chip_last |-> chip_valid ##1 (!chip_valid || chip_first);
   endproperty
   a_last: assert property (p_last) else $error("last flag without chip");
   property p_idle;
      !frame_active && !(sym_valid && sym_first) |=> !frame_active;
   endproperty
   a_idle: assert property (p_idle) else $error("frame began unasked");
   property p_ready;
      !frame_active && !$past(frame_active) && !chip_valid |-> sym_ready;
   endproperty
   a_ready: assert property (p_ready) else $error("not ready while idle");
   property p_quiet;
      $fell(rst) |-> !chip_valid && !frame_active;
   endproperty
   a_quiet: assert property (p_quiet) else $error("busy after reset");
   c_sf4: cover property (start && chips_per_symbol == 3'h4);
   c_end: cover property (chip_last);
   c_wait: cover property (sym_valid && !sym_ready);
endmodule : fls_spreader_sva

// ---- tb/fls_spreader_tb.sv ----
// testbench for the forward link spreader
`timescale 1ns/10ps
module fls_spreader_tb;
   logic clk, rst, go, slow, sym_valid, sym_first, sym_ready, chip_valid, chip_first, chip_last, frame_active;
   logic [2:0] chips_per_symbol;
   logic [3:0] spread_code;
   logic [17:0] gold_index;
   logic [23:0] frame_symbol_count;
   logic [15:0] val;
   fls_pkg::fls_sample_type sym_i, sym_q;
   fls_pkg::fls_chip_type chip_i, chip_q;
   fls_pkg::fls_chip_type qi[$], qq[$], si[$], sq[$];
   logic [1:0] qf[$];
   int err_total = 0;
   int checked = 0;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   fls_spreader i_dut (.clk(clk), .rst(rst), .chips_per_symbol(chips_per_symbol), .spread_code(spread_code),
      .gold_index(gold_index), .frame_symbol_count(frame_symbol_count), .sym_valid(sym_valid),
      .sym_first(sym_first), .sym_i(sym_i), .sym_q(sym_q), .sym_ready(sym_ready), .chip_valid(chip_valid),
      .chip_first(chip_first), .chip_last(chip_last), .chip_i(chip_i), .chip_q(chip_q), .frame_active(frame_active));
   fls_framer_model i_src (.clk(clk), .rst(rst), .go(go), .slow(slow), .n(frame_symbol_count), .val(val),
      .sym_ready(sym_ready), .sym_valid(sym_valid), .sym_first(sym_first), .sym_i(sym_i), .sym_q(sym_q));
   always @(posedge clk) begin
      if (chip_valid) begin
         qi.push_back(chip_i);
         qq.push_back(chip_q);
         qf.push_back({chip_first, chip_last});
      end
   end
   function automatic logic [31:0] mag(input logic signed [31:0] v);
      return v[31] ? -v : v;
   endfunction : mag
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic run_frame(input logic [2:0] sf, input logic [15:0] v, input logic sl, input logic poke,
      input logic [23:0] n);
      qi.delete();
      qq.delete();
      qf.delete();
      chips_per_symbol <= sf;
      spread_code <= 4'h5;
      val <= v;
      slow <= sl;
      frame_symbol_count <= n;
      gold_index <= 18'h00005;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      if (poke) begin
         chips_per_symbol <= 3'h3;
         spread_code <= 4'h9;
         gold_index <= 18'h00077;
      end
      for (int t = 0; t < 200 + 5 * int'(n) && !(chip_valid && chip_last); t++) @(negedge clk);
      repeat (2) @(posedge clk);
   endtask : run_frame
   task automatic t_sweep;
      int a;
      int rot;
      for (int sf = 1; sf <= 4; sf++) begin
         run_frame(3'(sf), 16'(sf * 50 - 100), sf == 3, 1'b0, 24'h000004);
         rot = 0;
         check(qi.size(), 4 * sf);
         for (int j = 0; j < 4 * sf; j++) begin
            a = sf * 50 - 100 + j / sf;
            check(mag(qi[j]), mag(a));
            check(mag(qq[j]), mag(a));
            check(qf[j], {j == 0, j == 4 * sf - 1});
            if (sf == 1) check(qi[j], a);
            if (qi[j] == qq[j] && qi[j] != 0) rot++;
         end
         check(rot > 0, sf > 1);
      end
      $display("test sweep done");
   endtask : t_sweep
   task automatic t_restart;
      run_frame(3'h2, 16'h0123, 1'b0, 1'b0, 24'h000004);
      si = qi;
      sq = qq;
      run_frame(3'h2, 16'h0123, 1'b0, 1'b1, 24'h000004);
      check(qi.size(), 8);
      for (int j = 0; j < 8; j++) begin
         check(qi[j], si[j]);
         check(qq[j], sq[j]);
      end
      $display("test restart done");
   endtask : t_restart
   task automatic t_clamp;
      run_frame(3'h7, 16'h0010, 1'b0, 1'b0, 24'h000004);
      check(qi.size(), 16);
      run_frame(3'h0, 16'h0010, 1'b0, 1'b0, 24'h000004);
      check(qi.size(), 4);
      $display("test clamp done");
   endtask : t_clamp
   task automatic t_wrap;
      run_frame(3'h4, 16'h0001, 1'b0, 1'b0, 24'h0040de);
      check(qi.size(), 66424);
      for (int j = 0; j < 4; j++) begin
         check({qi[j + 66420][16], qq[j + 66420][16]}, {qi[j][16], qq[j][16]});
      end
      $display("test wrap done");
   endtask : t_wrap
   task automatic wrap_up;
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      {rst, go, slow, val, chips_per_symbol, spread_code, gold_index} = {1'b1, 1'b0, 1'b0, 16'h0000, 3'h1, 4'h5, 18'h0};
      frame_symbol_count = 24'h000004;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_sweep();
      t_restart();
      t_clamp();
      t_wrap();
      wrap_up();
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      wrap_up();
   end
endmodule : fls_spreader_tb
bind fls_spreader fls_spreader_sva i_sva (.clk(clk), .rst(rst), .chips_per_symbol(chips_per_symbol),
   .sym_valid(sym_valid), .sym_first(sym_first), .sym_i(sym_i), .sym_q(sym_q), .sym_ready(sym_ready),
   .chip_valid(chip_valid), .chip_first(chip_first), .chip_last(chip_last), .chip_i(chip_i), .chip_q(chip_q),
   .frame_active(frame_active));
